// *** core/readout_cfg.svh ***
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH

// stored program size, one bit per location
`define POS_W          16
`define FIRST_POS      16'h0000
`define LAST_POS       16'hffff

// buffer word width
`define BUF_W          1

// synchroniser bit positions and idle levels
`define SYNC_W         5
`define SYNC_CLK       0
`define SYNC_CE_N      1
`define SYNC_RST_OE    2
`define SYNC_PROG_N    3
`define SYNC_POL       4
`define SYNC_IDLE      5'h0e

// internal power-on reset duration
`define CLK_PERIOD_NS  25
`define POR_TIME_NS    1000
`define POR_CYCLES     ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CNT_W      8
`define POR_CNT_LAST   8'((`POR_CYCLES) - 1)

`endif

// *** core/readout_pkg.sv ***
package readout_pkg;

	typedef enum logic [1:0] {
		ST_POWER_ON = 2'b00,
		ST_LOAD     = 2'b01,
		ST_PROGRAM  = 2'b10
	} readout_state_type;

endpackage

// *** core/config_store.sv ***
`timescale 1ns/1ps
`include "readout_cfg.svh"

module config_store (
	input  wire logic              clk,
	input  wire logic              rd_en,
	input  wire logic [`POS_W-1:0] rd_addr,
	output logic                   rd_data,
	input  wire logic              wr_en,
	input  wire logic [`POS_W-1:0] wr_addr,
	input  wire logic              wr_data
);

	logic mem [0:(1 << `POS_W) - 1];
	logic rd_data_nxt;

	always_comb begin
		rd_data_nxt = rd_data;
		if (rd_en) begin
			rd_data_nxt = mem[rd_addr];
		end
	end

	// no reset on the array: contents are the nonvolatile program
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= rd_data_nxt;
	end

endmodule // config_store

// *** core/bit_skid_buffer.sv ***
`timescale 1ns/1ps
`include "readout_cfg.svh"

module bit_skid_buffer (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              flush,
	input  wire logic              in_valid,
	input  wire logic [`BUF_W-1:0] in_data,
	output logic                   in_ready,
	output logic                   out_valid,
	output logic [`BUF_W-1:0]      out_data,
	input  wire logic              out_ready
);

	logic [`BUF_W-1:0] slot_r [0:1];
	logic [`BUF_W-1:0] slot_nxt [0:1];
	logic [1:0]        count_r;
	logic [1:0]        count_nxt;
	logic              push;
	logic              pop;

	assign in_ready  = (count_r != 2'h2);
	assign out_valid = (count_r != 2'h0);
	assign out_data  = slot_r[0];

	always_comb begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		slot_nxt[0] = slot_r[0];
		slot_nxt[1] = slot_r[1];
		count_nxt   = count_r;
		if (flush) begin
			count_nxt = 2'h0;
		end else begin
			if (pop) begin
				slot_nxt[0] = slot_r[1];
			end
			if (push) begin
				if (count_r == 2'h0 || (count_r == 2'h1 && pop)) begin
					slot_nxt[0] = in_data;
				end else begin
					slot_nxt[1] = in_data;
				end
			end
			count_nxt = count_r + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			count_r   <= 2'h0;
			slot_r[0] <= '0;
			slot_r[1] <= '0;
		end else begin
			count_r   <= count_nxt;
			slot_r[0] <= slot_nxt[0];
			slot_r[1] <= slot_nxt[1];
		end
	end

endmodule // bit_skid_buffer

// *** core/serial_config_memory_readout.sv ***
// What this block does
// - serial data output presents one stored bit at a time to the loader
// - cascade output feeds the next memory's active-low chip enable
// - ready pin driven low during power-on reset, released afterwards
// - clock after the final bit drives cascade low and turns data driver off
// - data driver disabled once read position passes the last bit
// - low chip enable lets this memory enable its own data output
// - active reset level after loading clears the address counters
// - reset/output-enable polarity chosen by the synchronised reset_active_high input
// - low programming enable input selects programming mode
// - memory writable in programming mode through the write port
// - chip enable high puts the device in low-power standby, except in programming mode
// - in standby the data output stays high impedance
// - active reset clears both counters; inactive with chip enable low drives data
// - chip enable low and enable active advance; ignored in programming mode
// - cascade low at end while enabled, follows chip enable, reset restores high
`timescale 1ns/1ps
`include "readout_cfg.svh"

module serial_config_memory_readout
	import readout_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              load_clock_out,
	input  wire logic              chip_enable_n,
	input  wire logic              reset_oe,
	input  wire logic              reset_active_high,
	input  wire logic              prog_mode_enable_n,
	input  wire logic              prog_wr_en,
	input  wire logic [`POS_W-1:0] prog_wr_addr,
	input  wire logic              prog_wr_data,
	output logic                   data_out,
	output logic                   data_oe_n,
	output logic                   cascade_enable_out_n,
	output logic                   ready_out,
	output logic                   ready_oe_n,
	output logic                   standby,
	output logic                   in_circuit_programming
);

	// pin synchronisers; stage one is read only by stage two
	logic [`SYNC_W-1:0] sync1_r;
	logic [`SYNC_W-1:0] sync2_r;
	logic               clk_prev_r;
	logic [`SYNC_W-1:0] sync1_nxt;

	// packed in the order of the sync bit positions
	always_comb begin
		sync1_nxt = {reset_active_high, prog_mode_enable_n, reset_oe,
			chip_enable_n, load_clock_out};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_r    <= `SYNC_IDLE;
			sync2_r    <= `SYNC_IDLE;
			// idle low, so leaving reset never fakes a shift edge
			clk_prev_r <= 1'b0;
		end else begin
			sync1_r    <= sync1_nxt;
			sync2_r    <= sync1_r;
			clk_prev_r <= sync2_r[`SYNC_CLK];
		end
	end

	logic ce_n_s;
	logic prog_n_s;
	logic shift_edge;
	logic reset_act;

	assign ce_n_s     = sync2_r[`SYNC_CE_N];
	assign prog_n_s   = sync2_r[`SYNC_PROG_N];
	assign shift_edge = sync2_r[`SYNC_CLK] && !clk_prev_r;

	assign reset_act  = sync2_r[`SYNC_POL] ? sync2_r[`SYNC_RST_OE] : !sync2_r[`SYNC_RST_OE];

	// mode control and power-on timing
	readout_state_type    state_r;
	readout_state_type    state_nxt;
	logic [`POR_CNT_W-1:0] por_cnt_r;
	logic [`POR_CNT_W-1:0] por_cnt_nxt;

	always_comb begin
		state_nxt   = state_r;
		por_cnt_nxt = por_cnt_r;
		case (state_r)
			ST_POWER_ON: begin
				por_cnt_nxt = por_cnt_r + 8'h01;
				if (por_cnt_r == `POR_CNT_LAST) begin
					state_nxt = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (!prog_n_s) begin
					state_nxt = ST_PROGRAM;
				end
			end
			ST_PROGRAM: begin
				// counters stay flushed here, so leaving restarts at bit 0
				if (prog_n_s) begin
					state_nxt = ST_LOAD;
				end
			end
			default: begin
				state_nxt = ST_POWER_ON;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r   <= ST_POWER_ON;
			por_cnt_r <= 8'h00;
		end else begin
			state_r   <= state_nxt;
			por_cnt_r <= por_cnt_nxt;
		end
	end

	// read position and end-of-program tracking
	logic              flush;
	logic              active;
	logic              advance;
	logic [`POS_W-1:0] pos_r;
	logic [`POS_W-1:0] pos_nxt;
	logic              done_r;
	logic              done_nxt;

	always_comb begin
		// counters held at first bit during power-on or reset
		flush    = (state_r != ST_LOAD) || reset_act;
		// counting needs load mode, chip enable low, enable active
		active   = (state_r == ST_LOAD) && !ce_n_s && !reset_act;
		advance  = active && shift_edge && !done_r;
		pos_nxt  = pos_r;
		done_nxt = done_r;
		if (flush) begin
			pos_nxt  = `FIRST_POS;
			done_nxt = 1'b0;
		end else if (advance) begin
			if (pos_r == `LAST_POS) begin
				// past the final bit
				// position parks on the last bit; a reset level or a pass through programming mode restarts
				done_nxt = 1'b1;
			end else begin
				pos_nxt = pos_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pos_r  <= `FIRST_POS;
			done_r <= 1'b0;
		end else begin
			pos_r  <= pos_nxt;
			done_r <= done_nxt;
		end
	end

	// prefetch side: memory read feeds the two-entry buffer
	logic              rd_en;
	logic              rd_data;
	logic              pend_r;
	logic              pend_nxt;
	logic [`POS_W-1:0] fpos_r;
	logic [`POS_W-1:0] fpos_nxt;
	logic              fdone_r;
	logic              fdone_nxt;
	logic              buf_in_ready;
	logic              buf_out_valid;
	logic              buf_out_data;
	logic              buf_out_ready;
	logic              wr_en;

	assign wr_en = prog_wr_en && (state_r == ST_PROGRAM);

	// fetch runs ahead so the next bit already waits at each shift edge
	always_comb begin
		rd_en     = !flush && !pend_r && !fdone_r;
		pend_nxt  = pend_r;
		fpos_nxt  = fpos_r;
		fdone_nxt = fdone_r;
		if (flush) begin
			pend_nxt  = 1'b0;
			fpos_nxt  = `FIRST_POS;
			fdone_nxt = 1'b0;
		end else if (rd_en) begin
			pend_nxt = 1'b1;
		end else if (pend_r && buf_in_ready) begin
			// buffer full stalls the fetch here
			pend_nxt = 1'b0;
			if (fpos_r == `LAST_POS) begin
				fdone_nxt = 1'b1;
			end else begin
				fpos_nxt = fpos_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pend_r  <= 1'b0;
			fpos_r  <= `FIRST_POS;
			fdone_r <= 1'b0;
		end else begin
			pend_r  <= pend_nxt;
			fpos_r  <= fpos_nxt;
			fdone_r <= fdone_nxt;
		end
	end

	config_store u_store (
		.clk     (clk),
		.rd_en   (rd_en),
		.rd_addr (fpos_r),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_addr (prog_wr_addr),
		.wr_data (prog_wr_data)
	);

	bit_skid_buffer u_buf (
		.clk       (clk),
		.srst      (srst),
		.flush     (flush),
		.in_valid  (pend_r),
		.in_data   (rd_data),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (buf_out_ready)
	);

	// output stage and pin drivers
	logic cur_valid_r;
	logic cur_valid_nxt;
	logic data_out_nxt;
	logic data_oe_n_nxt;
	logic cascade_nxt;
	logic ready_oe_n_nxt;
	logic standby_nxt;
	logic ready_out_nxt;
	logic prog_out_nxt;

	// pop on first fill and on each advance; an empty buffer only delays data
	assign buf_out_ready = !cur_valid_r || advance;

	always_comb begin
		cur_valid_nxt = cur_valid_r;
		data_out_nxt  = data_out;
		if (flush) begin
			cur_valid_nxt = 1'b0;
		end else if (buf_out_ready) begin
			cur_valid_nxt = buf_out_valid;
			// next stored bit onto the data pin
			if (buf_out_valid) begin
				data_out_nxt = buf_out_data;
			end
		end
		// drive only when selected, enabled and not finished
		data_oe_n_nxt  = !(active && !done_nxt);
		// cascade low after the end while chip enable is low
		cascade_nxt    = !(done_nxt && !ce_n_s && (state_r == ST_LOAD));
		// open-drain ready pulled low during power-on
		ready_oe_n_nxt = (state_nxt == ST_POWER_ON) ? 1'b0 : 1'b1;
		// standby follows chip enable outside programming
		// also high during power-on while chip enable is high
		standby_nxt    = ce_n_s && (state_r != ST_PROGRAM);
		// open-drain pin: value always low, only the enable moves
		ready_out_nxt  = 1'b0;
		prog_out_nxt   = (state_nxt == ST_PROGRAM);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cur_valid_r            <= 1'b0;
			data_out               <= 1'b0;
			data_oe_n              <= 1'b1;
			cascade_enable_out_n   <= 1'b1;
			ready_out              <= 1'b0;
			ready_oe_n             <= 1'b0;
			standby                <= 1'b1;
			in_circuit_programming <= 1'b0;
		end else begin
			cur_valid_r            <= cur_valid_nxt;
			data_out               <= data_out_nxt;
			data_oe_n              <= data_oe_n_nxt;
			cascade_enable_out_n   <= cascade_nxt;
			ready_out              <= ready_out_nxt;
			ready_oe_n             <= ready_oe_n_nxt;
			standby                <= standby_nxt;
			in_circuit_programming <= prog_out_nxt;
		end
	end

endmodule // serial_config_memory_readout

// *** bench/readout_assertions.sv ***
`timescale 1ns/1ps

module readout_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire logic chip_enable_n,
	input wire logic reset_oe,
	input wire logic reset_active_high,
	input wire logic prog_mode_enable_n,
	input wire logic data_oe_n,
	input wire logic cascade_enable_out_n,
	input wire logic ready_out,
	input wire logic ready_oe_n,
	input wire logic standby,
	input wire logic in_circuit_programming
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	logic rst_on;
	assign rst_on = reset_oe == reset_active_high;

	ready_value_a: assert property (ready_out == 1'b0)
		else $error("ready pin value not low");
	ready_hold_a: assert property ($fell(srst) |-> !ready_oe_n [*8])
		else $error("ready released too early");
	ready_release_a: assert property ($fell(srst) |-> ##[30:60] ready_oe_n)
		else $error("ready never released");
	standby_enter_a: assert property
		((chip_enable_n && prog_mode_enable_n) [*5] |=> standby)
		else $error("no standby with chip enable high");
	standby_float_a: assert property (standby && $past(standby) |-> data_oe_n)
		else $error("data driven in standby");
	prog_entry_a: assert property
		((!prog_mode_enable_n) [*5] |=> in_circuit_programming && !standby)
		else $error("programming mode not entered");
	reset_clear_a: assert property
		(rst_on [*5] |=> data_oe_n && cascade_enable_out_n)
		else $error("reset level did not stop output");
	enable_drive_a: assert property
		((!chip_enable_n && !rst_on && prog_mode_enable_n && ready_oe_n) [*8]
		|=> data_oe_n == !cascade_enable_out_n)
		else $error("data driver not following enable");
	cascade_off_a: assert property (!cascade_enable_out_n |-> data_oe_n)
		else $error("data driven after last bit");
	cascade_follow_a: assert property (chip_enable_n [*5] |=> cascade_enable_out_n)
		else $error("cascade low with chip enable high");

	cover property ($rose(ready_oe_n));
	cover property ($rose(in_circuit_programming));
	cover property ($fell(data_oe_n));
endmodule // readout_assertions

// *** bench/loader_model.sv ***
`timescale 1ns/1ps

module loader_model (
	input  wire logic clk,
	input  wire logic data_out,
	input  wire logic data_oe_n,
	output logic      load_clock_out
);
	logic last;

	initial load_clock_out = 1'b0;
	initial last = 1'b0;

	task automatic shift(output logic b);
		@(negedge clk);
		// released line shows the inverse, never a stale match
		b = data_oe_n ? ~last : data_out;
		last = b;
		@(posedge clk);
		load_clock_out <= 1'b1;
		repeat (3) @(posedge clk);
		load_clock_out <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
endmodule // loader_model

// *** bench/serial_config_memory_readout_bench.sv ***
`timescale 1ns/1ps
`include "readout_cfg.svh"

module serial_config_memory_readout_bench;
	localparam logic [15:0] pat = 16'hc5a3;
	logic              clk, srst, load_clock_out, chip_enable_n, reset_oe;
	logic              reset_active_high, prog_mode_enable_n, prog_wr_en, prog_wr_data;
	logic [`POS_W-1:0] prog_wr_addr;
	logic              data_out, data_oe_n, cascade_enable_out_n, ready_out;
	logic              ready_oe_n, standby, in_circuit_programming, b;
	int                n_mismatch = 0;
	int                samples_checked = 0;
	int                cycles = 0;

	serial_config_memory_readout dut (.clk, .srst, .load_clock_out, .chip_enable_n,
		.reset_oe, .reset_active_high, .prog_mode_enable_n, .prog_wr_en, .prog_wr_addr,
		.prog_wr_data, .data_out, .data_oe_n, .cascade_enable_out_n, .ready_out,
		.ready_oe_n, .standby, .in_circuit_programming);
	loader_model lm (.clk, .data_out, .data_oe_n, .load_clock_out);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// run is a few hundred cycles; ceiling leaves wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// pins pass 2 sync flops, edge detect and prefetch before settling
	task automatic pins(input logic ce, input logic ro, input logic pol, input logic pg);
		@(posedge clk);
		chip_enable_n <= ce;
		reset_oe <= ro;
		reset_active_high <= pol;
		prog_mode_enable_n <= pg;
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic d);
		@(posedge clk);
		prog_wr_en <= 1'b1;
		prog_wr_addr <= a;
		prog_wr_data <= d;
		@(posedge clk);
		prog_wr_en <= 1'b0;
	endtask

	task automatic rd(input int n, input int lo, input string what);
		logic v;
		for (int i = 0; i < n; i++) begin
			lm.shift(v);
			chk(v, pat[lo+i], what);
		end
	endtask

	initial begin
		srst = 1'b1;
		chip_enable_n = 1'b1;
		reset_oe = 1'b1;
		reset_active_high = 1'b1;
		prog_mode_enable_n = 1'b1;
		prog_wr_en = 1'b0;
		prog_wr_addr = 16'h0000;
		prog_wr_data = 1'b0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk(ready_oe_n, 1'b0, "ready early");
		chk(ready_out, 1'b0, "ready level");
		chk(data_oe_n, 1'b1, "data early");
		repeat (46) @(posedge clk);
		#1;
		chk(ready_oe_n, 1'b1, "ready late");
		$display("test power-on done");
		pins(1'b1, 1'b1, 1'b1, 1'b0);
		chk(in_circuit_programming, 1'b1, "prog mode");
		chk(standby, 1'b0, "prog standby");
		for (int i = 0; i < 16; i++)
			wr(16'(i), pat[i]);
		$display("test programming done");
		// keep reset inactive so the position is kept
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		chk(in_circuit_programming, 1'b0, "load mode");
		chk(data_oe_n, 1'b0, "drive");
		chk(standby, 1'b0, "awake");
		rd(8, 0, "first bits");
		$display("test readout done");
		pins(1'b1, 1'b0, 1'b1, 1'b1);
		chk(standby, 1'b1, "standby");
		chk(data_oe_n, 1'b1, "standby float");
		chk(cascade_enable_out_n, 1'b1, "cascade");
		repeat (2) lm.shift(b);
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		rd(4, 8, "held position");
		$display("test standby done");
		// write outside programming mode must not reach the array
		wr(16'h0000, ~pat[0]);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		chk(data_oe_n, 1'b1, "reset float");
		chk(cascade_enable_out_n, 1'b1, "reset cascade");
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		rd(4, 0, "restart");
		$display("test reset done");
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		chk(data_oe_n, 1'b1, "low active reset");
		pins(1'b0, 1'b1, 1'b0, 1'b1);
		chk(data_oe_n, 1'b0, "high enables");
		rd(4, 0, "low polarity");
		$display("test polarity done");
		tally_and_finish();
	end
endmodule // serial_config_memory_readout_bench

bind serial_config_memory_readout readout_assertions chk_i (.clk, .srst, .chip_enable_n,
	.reset_oe, .reset_active_high, .prog_mode_enable_n, .data_oe_n,
	.cascade_enable_out_n, .ready_out, .ready_oe_n, .standby, .in_circuit_programming);
